// ==== rtl/sbr_defs.vh ====
// Register offsets, field layout, reset values and channel codes of the result/limit bank
`ifndef SBR_DEFS_VH
`define SBR_DEFS_VH

// ==========================================================
// Register pointer values
`define SBR_PTR_CHAN2_SHUNT 8'h03
`define SBR_PTR_CHAN2_BUS 8'h04
`define SBR_PTR_CHAN3_SHUNT 8'h05
`define SBR_PTR_CHAN3_BUS 8'h06
`define SBR_PTR_CHAN1_FAST 8'h07
`define SBR_PTR_CHAN1_SLOW 8'h08
`define SBR_PTR_CHAN2_FAST 8'h09

// ==========================================================
// Field layout: sign bit 15, magnitude 14..3, reserved 2..0
`define SBR_SIGN_BIT 15
`define SBR_MAG_MSB 14
`define SBR_MAG_LSB 3
`define SBR_DATA_MASK 16'hFFF8

// ==========================================================
// Reset values
`define SBR_RESULT_RESET 16'h0000
`define SBR_LIMIT_RESET 16'h7FF8
`define SBR_UNMAPPED_READ 16'h0000

// ==========================================================
// Channel codes on the converter ports
`define SBR_CHAN1 2'h1
`define SBR_CHAN2 2'h2
`define SBR_CHAN3 2'h3

// ==========================================================
// Serial bus: default 7-bit target address (arbitrary value)
`define SBR_DEV_ADDR 7'h40
`define SBR_BITS_PER_BYTE 4'h8

`endif

// ==== rtl/sbr_sync.v ====
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
`default_nettype none

module sbr_sync (
   input wire clk_sys,
   input wire rst_n,
   input wire async_in,
   output reg sync_out
);

   reg stage1;

   // ==========================================================
   // Synchroniser: stage1 is read only by sync_out
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule // sbr_sync

`default_nettype wire

// ==== rtl/sbr_limit_cmp.v ====
// Signed comparison of one shunt sample against one limit word
`timescale 1ns/10ps
`default_nettype none
`include "sbr_defs.vh"

module sbr_limit_cmp (
   input wire [15:0] sample,
   input wire [15:0] limit,
   output wire exceed
);

   // ==========================================================
   // Both words use the same signed 40 uV step; reserved bits ignored
   assign exceed = $signed(sample & `SBR_DATA_MASK) > $signed(limit & `SBR_DATA_MASK);

endmodule // sbr_limit_cmp

`default_nettype wire

// ==== rtl/sbr_top.v ====
// Result and limit register bank with its serial target port and overcurrent compare
// ==========================================================
// How it works
// - Averaged shunt results of channels 2 and 3 held at pointers 03h and 05h.
// - Shunt code 7FF8 means 163.8 mV full scale, 40 uV per step.
// - Bit 15 is sign, two's complement; bits 14..3 carry the magnitude.
// - Latest bus readings of channels 2 and 3 held at pointers 04h and 06h.
// - Bus code 7FF8 means 32.76 V full scale, 8 mV per step.
// - All result registers are read-only and reset to zero.
// - Raw channel-1 and channel-2 shunt conversions checked against their own fast limits.
// - Averaged channel-1 shunt result checked against the channel-1 slow limit.
// - Limits are read/write, data bits 15..3, reset value 7FF8h.
`timescale 1ns/10ps
`default_nettype none
`include "sbr_defs.vh"

module sbr_top #(
   parameter [6:0] DEV_ADDR = `SBR_DEV_ADDR
) (
   input wire clk_sys,
   input wire reset_n,
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   input wire conv_shunt_valid,
   input wire [1:0] conv_shunt_chan,
   input wire [15:0] conv_shunt_data,
   input wire avg_shunt_valid,
   input wire [1:0] avg_shunt_chan,
   input wire [15:0] avg_shunt_data,
   input wire bus_valid,
   input wire [1:0] bus_chan,
   input wire [15:0] bus_data,
   output reg chan1_fast_flag,
   output reg chan2_fast_flag,
   output reg chan1_slow_flag
);

   // Serial engine states, one-hot
   localparam [4:0] ST_IDLE = 5'b00001, ST_RX = 5'b00010, ST_ACK = 5'b00100,
      ST_TX = 5'b01000, ST_TXACK = 5'b10000;
   // Byte roles within a transaction
   localparam [1:0] BY_ADDR = 2'h0, BY_PTR = 2'h1, BY_HI = 2'h2, BY_LO = 2'h3;

   reg rst_meta, rst_n, scl_d, sda_d, tx_half, read_dir, master_ack;
   wire scl_s, sda_s, scl_rise, scl_fall, start_cond, stop_cond, reg_write;
   reg [4:0] state;
   reg [3:0] bit_cnt;
   reg [1:0] byte_idx;
   reg [7:0] rx_shift, pointer, wr_hi;
   reg [15:0] tx_shift, read_word;
   reg [15:0] chan2_shunt_result, chan2_bus_result, chan3_shunt_result, chan3_bus_result;
   reg [15:0] chan1_fast_overcurrent_limit, chan1_slow_overcurrent_limit;
   reg [15:0] chan2_fast_overcurrent_limit;
   wire [15:0] write_word;
   wire chan1_fast_exceed, chan2_fast_exceed, chan1_slow_exceed;

   // Clears the reserved low bits of a data word
   function [15:0] keep_data;
      input [15:0] word;
      begin
         keep_data = word & `SBR_DATA_MASK;
      end
   endfunction

   // ==========================================================
   // Reset release
   // Async assert, release through two flops so no flop sees a ragged edge
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ==========================================================
   // Pin synchronisers and bus condition detect
   sbr_sync u_sync_scl (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in(scl_in),
      .sync_out(scl_s)
   );

   sbr_sync u_sync_sda (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in(sda_in),
      .sync_out(sda_s)
   );

   // Delayed copies for edge detection, taken after the synchronisers
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

   // ==========================================================
   // Register read multiplexer
   // Unmapped pointers read as zero rather than echoing stale data
   always @* begin
      case (pointer)
         `SBR_PTR_CHAN2_SHUNT: read_word = chan2_shunt_result;
         `SBR_PTR_CHAN2_BUS: read_word = chan2_bus_result;
         `SBR_PTR_CHAN3_SHUNT: read_word = chan3_shunt_result;
         `SBR_PTR_CHAN3_BUS: read_word = chan3_bus_result;
         `SBR_PTR_CHAN1_FAST: read_word = chan1_fast_overcurrent_limit;
         `SBR_PTR_CHAN1_SLOW: read_word = chan1_slow_overcurrent_limit;
         `SBR_PTR_CHAN2_FAST: read_word = chan2_fast_overcurrent_limit;
         default: read_word = `SBR_UNMAPPED_READ;
      endcase
   end

   // A write lands when the low data byte is complete, on the SCL fall that starts its acknowledge
   assign reg_write = (state == ST_RX) & scl_fall & (bit_cnt == `SBR_BITS_PER_BYTE)
                      & (byte_idx == BY_LO);
   assign write_word = keep_data({wr_hi, rx_shift});

   // ==========================================================
   // Serial target engine
   // Bits are sampled on SCL rise and driven on SCL fall; no clock stretching
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         rx_shift <= 8'h00;
         tx_shift <= 16'h0000;
         tx_half <= 1'b0;
         byte_idx <= BY_ADDR;
         read_dir <= 1'b0;
         master_ack <= 1'b0;
         pointer <= 8'h00;
         wr_hi <= 8'h00;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end else if (start_cond) begin
         // Start or repeated start restarts the address phase
         state <= ST_RX;
         bit_cnt <= 4'h0;
         byte_idx <= BY_ADDR;
         sda_oe <= 1'b0;
      end else if (stop_cond) begin
         state <= ST_IDLE;
         sda_oe <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               sda_oe <= 1'b0;
            end
            ST_RX: begin
               if (scl_rise && bit_cnt != `SBR_BITS_PER_BYTE) begin
                  rx_shift <= {rx_shift[6:0], sda_s};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == `SBR_BITS_PER_BYTE) begin
                  bit_cnt <= 4'h0;
                  state <= ST_ACK;
                  sda_oe <= 1'b1;
                  case (byte_idx)
                     BY_ADDR: begin
                        if (rx_shift[7:1] == DEV_ADDR) begin
                           read_dir <= rx_shift[0];
                        end else begin
                           // Not our address: stay off the bus until next start
                           state <= ST_IDLE;
                           sda_oe <= 1'b0;
                        end
                     end
                     BY_PTR: begin
                        pointer <= rx_shift;
                     end
                     BY_HI: begin
                        wr_hi <= rx_shift;
                     end
                     default: begin
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (read_dir && byte_idx == BY_ADDR) begin
                     // Snapshot whole word so both bytes come from one value
                     tx_shift <= {read_word[14:0], 1'b0};
                     sda_oe <= ~read_word[15];
                     tx_half <= 1'b0;
                     bit_cnt <= 4'h1;
                     state <= ST_TX;
                  end else begin
                     sda_oe <= 1'b0;
                     state <= ST_RX;
                     byte_idx <= (byte_idx == BY_LO) ? BY_HI : byte_idx + 2'h1;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt == `SBR_BITS_PER_BYTE) begin
                     sda_oe <= 1'b0;
                     bit_cnt <= 4'h0;
                     state <= ST_TXACK;
                  end else begin
                     sda_oe <= ~tx_shift[15];
                     tx_shift <= {tx_shift[14:0], 1'b0};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            ST_TXACK: begin
               if (scl_rise) begin
                  master_ack <= ~sda_s;
               end else if (scl_fall) begin
                  if (!master_ack) begin
                     // Host said done; release and wait for stop
                     state <= ST_IDLE;
                     sda_oe <= 1'b0;
                  end else if (!tx_half) begin
                     sda_oe <= ~tx_shift[15];
                     tx_shift <= {tx_shift[14:0], 1'b0};
                     tx_half <= 1'b1;
                     bit_cnt <= 4'h1;
                     state <= ST_TX;
                  end else begin
                     // Continued reads repeat the same register, refreshed
                     sda_oe <= ~read_word[15];
                     tx_shift <= {read_word[14:0], 1'b0};
                     tx_half <= 1'b0;
                     bit_cnt <= 4'h1;
                     state <= ST_TX;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Limit registers, host writable
   // Reserved bits hold zero; writes to result pointers are dropped
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chan1_fast_overcurrent_limit <= `SBR_LIMIT_RESET;
         chan1_slow_overcurrent_limit <= `SBR_LIMIT_RESET;
         chan2_fast_overcurrent_limit <= `SBR_LIMIT_RESET;
      end else if (reg_write) begin
         case (pointer)
            `SBR_PTR_CHAN1_FAST: chan1_fast_overcurrent_limit <= write_word;
            `SBR_PTR_CHAN1_SLOW: chan1_slow_overcurrent_limit <= write_word;
            `SBR_PTR_CHAN2_FAST: chan2_fast_overcurrent_limit <= write_word;
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Result registers, loaded only by the converter
   // Codes pass with reserved bits cleared: 40 uV or 8 mV per step, sign in bit 15
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chan2_shunt_result <= `SBR_RESULT_RESET;
         chan3_shunt_result <= `SBR_RESULT_RESET;
         chan2_bus_result <= `SBR_RESULT_RESET;
         chan3_bus_result <= `SBR_RESULT_RESET;
      end else begin
         if (avg_shunt_valid && avg_shunt_chan == `SBR_CHAN2) begin
            chan2_shunt_result <= keep_data(avg_shunt_data);
         end
         if (avg_shunt_valid && avg_shunt_chan == `SBR_CHAN3) begin
            chan3_shunt_result <= keep_data(avg_shunt_data);
         end
         if (bus_valid && bus_chan == `SBR_CHAN2) begin
            chan2_bus_result <= keep_data(bus_data);
         end
         if (bus_valid && bus_chan == `SBR_CHAN3) begin
            chan3_bus_result <= keep_data(bus_data);
         end
      end
   end

   // ==========================================================
   // Overcurrent compare
   sbr_limit_cmp u_cmp_c1_fast (.sample(conv_shunt_data), .limit(chan1_fast_overcurrent_limit),
      .exceed(chan1_fast_exceed));
   sbr_limit_cmp u_cmp_c2_fast (.sample(conv_shunt_data), .limit(chan2_fast_overcurrent_limit),
      .exceed(chan2_fast_exceed));
   sbr_limit_cmp u_cmp_c1_slow (.sample(avg_shunt_data), .limit(chan1_slow_overcurrent_limit),
      .exceed(chan1_slow_exceed));

   // Flags hold the verdict of the latest relevant sample until the next one
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chan1_fast_flag <= 1'b0;
         chan2_fast_flag <= 1'b0;
         chan1_slow_flag <= 1'b0;
      end else begin
         if (conv_shunt_valid && conv_shunt_chan == `SBR_CHAN1) begin
            chan1_fast_flag <= chan1_fast_exceed;
         end
         if (conv_shunt_valid && conv_shunt_chan == `SBR_CHAN2) begin
            chan2_fast_flag <= chan2_fast_exceed;
         end
         if (avg_shunt_valid && avg_shunt_chan == `SBR_CHAN1) begin
            chan1_slow_flag <= chan1_slow_exceed;
         end
      end
   end

endmodule // sbr_top

`default_nettype wire

// ==== verification/sbr_host.sv ====
// Host model that drives the two-wire register bus of the result and limit bank
`timescale 1ns/10ps
`default_nettype none
// ========
// Bus host
module sbr_host (
   input wire logic clk_sys,
   input wire logic sda_in,
   output var logic scl,
   output var logic sda_low
);
   // Idle bus: clock parked high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Six clocks per phase keeps every phase above the 250 ns minimum
   task hp;
      repeat (6) @(posedge clk_sys);
   endtask
   // Data set while the clock is low and sampled late in the high phase
   task bit_io(input logic b, output logic r);
      sda_low <= !b;
      hp;
      scl <= 1'b1;
      hp;
      r = sda_in;
      scl <= 1'b0;
      hp;
   endtask
   // Release data first, so this also serves as a repeated start
   task start;
      sda_low <= 1'b0;
      hp;
      scl <= 1'b1;
      hp;
      sda_low <= 1'b1;
      hp;
      scl <= 1'b0;
      hp;
   endtask
   task stop;
      sda_low <= 1'b1;
      hp;
      scl <= 1'b1;
      hp;
      sda_low <= 1'b0;
      hp;
   endtask
   // Byte out, then the target's acknowledge
   task wb(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask
   // Byte in; last is our not-acknowledge
   task rb(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(last, r);
   endtask
endmodule // sbr_host
`default_nettype wire

// ==== verification/sbr_chk_sva.sv ====
// Concurrent checks on the ports of the result and limit bank
`timescale 1ns/10ps
`default_nettype none
// ========
// Flag, pin and reset checks
module sbr_chk (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic conv_shunt_valid,
   input wire logic [1:0] conv_shunt_chan,
   input wire logic [15:0] conv_shunt_data,
   input wire logic avg_shunt_valid,
   input wire logic [1:0] avg_shunt_chan,
   input wire logic [15:0] avg_shunt_data,
   input wire logic bus_valid,
   input wire logic [1:0] bus_chan,
   input wire logic [15:0] bus_data,
   input wire logic chan1_fast_flag,
   input wire logic chan2_fast_flag,
   input wire logic chan1_slow_flag
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   // Most negative codes: no limit can lie below them
   sequence s_floor1;
      conv_shunt_valid && conv_shunt_chan == 2'h1 && conv_shunt_data[15:3] == 13'h1000;
   endsequence
   sequence s_floor2;
      conv_shunt_valid && conv_shunt_chan == 2'h2 && conv_shunt_data[15:3] == 13'h1000;
   endsequence
   sequence s_floora;
      avg_shunt_valid && avg_shunt_chan == 2'h1 && avg_shunt_data[15:3] == 13'h1000;
   endsequence
   AST_FAST1_FLOOR: assert property (s_floor1 |=> !chan1_fast_flag)
      else $error("chan1 fast flag set by most negative sample");
   AST_FAST2_FLOOR: assert property (s_floor2 |=> !chan2_fast_flag)
      else $error("chan2 fast flag set by most negative sample");
   AST_SLOW1_FLOOR: assert property (s_floora |=> !chan1_slow_flag)
      else $error("chan1 slow flag set by most negative average");
   // A flag may only move one cycle after its own source
   AST_FAST1_CAUSE: assert property ($changed(chan1_fast_flag) |->
      $past(conv_shunt_valid) && $past(conv_shunt_chan) == 2'h1)
      else $error("chan1 fast flag moved without raw chan1 sample");
   AST_FAST2_CAUSE: assert property ($changed(chan2_fast_flag) |->
      $past(conv_shunt_valid) && $past(conv_shunt_chan) == 2'h2)
      else $error("chan2 fast flag moved without raw chan2 sample");
   AST_SLOW1_CAUSE: assert property ($changed(chan1_slow_flag) |->
      $past(avg_shunt_valid) && $past(avg_shunt_chan) == 2'h1)
      else $error("chan1 slow flag moved without chan1 average");
   // Open-drain pin: only the enable moves, and only while the clock is low
   AST_OUT_LOW: assert property (sda_out == 1'b0)
      else $error("data pin value not low");
   AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data pin enable moved while clock high");
   AST_OE_STANDS: assert property ($rose(sda_oe) |=> sda_oe [*4])
      else $error("data pin enable dropped early");
   AST_RESET_QUIET: assert property ($rose(reset_n) |->
      (!chan1_fast_flag && !chan2_fast_flag && !chan1_slow_flag && !sda_oe) [*2])
      else $error("outputs active right after reset");
endmodule // sbr_chk
`default_nettype wire

// ==== verification/sbr_top_tb.sv ====
// Self-checking bench for the result and limit register bank
`timescale 1ns/10ps
`default_nettype none
`include "sbr_defs.vh"
// ========
// Bench top
module sbr_top_tb;
   typedef struct packed {
      logic [1:0] src;
      logic [1:0] ch;
      logic [7:0] ptr;
      logic [15:0] din;
      logic [15:0] exp;
   } sbr_row_t;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic conv_shunt_valid = 1'b0;
   logic [1:0] conv_shunt_chan = 2'h0;
   logic [15:0] conv_shunt_data = 16'h0000;
   logic avg_shunt_valid = 1'b0;
   logic [1:0] avg_shunt_chan = 2'h0;
   logic [15:0] avg_shunt_data = 16'h0000;
   logic bus_valid = 1'b0;
   logic [1:0] bus_chan = 2'h0;
   logic [15:0] bus_data = 16'h0000;
   logic scl;
   logic sda_low;
   wire sda_out;
   wire sda_oe;
   wire chan1_fast_flag;
   wire chan2_fast_flag;
   wire chan1_slow_flag;
   wire sda_w;
   int n_errors = 0;
   int cmp_count = 0;
   // Source 0 read only, 1 host write, 2 averaged shunt, 3 bus reading
   sbr_row_t rows [0:16] = '{
      '{2'h0, 2'h0, 8'h03, 16'h0000, 16'h0000},
      '{2'h0, 2'h0, 8'h04, 16'h0000, 16'h0000},
      '{2'h0, 2'h0, 8'h05, 16'h0000, 16'h0000},
      '{2'h0, 2'h0, 8'h06, 16'h0000, 16'h0000},
      '{2'h0, 2'h0, 8'h07, 16'h0000, 16'h7FF8},
      '{2'h0, 2'h0, 8'h08, 16'h0000, 16'h7FF8},
      '{2'h0, 2'h0, 8'h09, 16'h0000, 16'h7FF8},
      '{2'h0, 2'h0, 8'h0A, 16'h0000, 16'h0000},
      '{2'h1, 2'h0, 8'h07, 16'h1234, 16'h1230},
      '{2'h1, 2'h0, 8'h08, 16'h8007, 16'h8000},
      '{2'h1, 2'h0, 8'h09, 16'h0000, 16'h0000},
      '{2'h1, 2'h0, 8'h03, 16'hFFFF, 16'h0000},
      '{2'h2, 2'h2, 8'h03, 16'h1237, 16'h1230},
      '{2'h2, 2'h3, 8'h05, 16'hC180, 16'hC180},
      '{2'h3, 2'h2, 8'h04, 16'hFFFF, 16'hFFF8},
      '{2'h3, 2'h3, 8'h06, 16'h7FF8, 16'h7FF8},
      '{2'h2, 2'h1, 8'h03, 16'h4000, 16'h1230}
   };
   // Open-drain data line with pull-up
   assign sda_w = !(sda_oe || sda_low);
   always #25 clk_sys = !clk_sys;
   sbr_top #(.DEV_ADDR(`SBR_DEV_ADDR)) dut_u (.clk_sys, .reset_n, .scl_in(scl),
      .sda_in(sda_w), .sda_out, .sda_oe, .conv_shunt_valid, .conv_shunt_chan,
      .conv_shunt_data, .avg_shunt_valid, .avg_shunt_chan, .avg_shunt_data,
      .bus_valid, .bus_chan, .bus_data, .chan1_fast_flag, .chan2_fast_flag,
      .chan1_slow_flag);
   sbr_host host_u (.clk_sys, .sda_in(sda_w), .scl, .sda_low);
   task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task test_done;
      $display("Checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task do_reset;
      reset_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask
   // One-cycle converter pulse; 0 raw, 2 averaged, 3 bus
   task pulse(input logic [1:0] sel, input logic [1:0] ch, input logic [15:0] d);
      @(posedge clk_sys);
      conv_shunt_chan <= ch;
      avg_shunt_chan <= ch;
      bus_chan <= ch;
      conv_shunt_data <= d;
      avg_shunt_data <= d;
      bus_data <= d;
      conv_shunt_valid <= (sel == 2'h0);
      avg_shunt_valid <= (sel == 2'h2);
      bus_valid <= (sel == 2'h3);
      @(posedge clk_sys);
      conv_shunt_valid <= 1'b0;
      avg_shunt_valid <= 1'b0;
      bus_valid <= 1'b0;
      #1;
   endtask
   task fl(input logic [2:0] e);
      chk("flags", {13'h0000, chan1_fast_flag, chan2_fast_flag, chan1_slow_flag},
         {13'h0000, e});
   endtask
   task wr(input logic [7:0] p, input logic [15:0] d);
      logic [3:0] a;
      host_u.start;
      host_u.wb({`SBR_DEV_ADDR, 1'b0}, a[3]);
      host_u.wb(p, a[2]);
      host_u.wb(d[15:8], a[1]);
      host_u.wb(d[7:0], a[0]);
      host_u.stop;
      chk("write ack", {12'h000, a}, 16'h000F);
   endtask
   task rd(input logic [7:0] p, output logic [15:0] d);
      logic [2:0] a;
      host_u.start;
      host_u.wb({`SBR_DEV_ADDR, 1'b0}, a[2]);
      host_u.wb(p, a[1]);
      host_u.start;
      host_u.wb({`SBR_DEV_ADDR, 1'b1}, a[0]);
      host_u.rb(1'b0, d[15:8]);
      host_u.rb(1'b1, d[7:0]);
      host_u.stop;
      chk("read ack", {13'h0000, a}, 16'h0007);
   endtask
   // Hang guard
   initial begin
      repeat (90000) @(posedge clk_sys);
      n_errors++;
      test_done;
   end
   // Table run, then flag edge cases and a second reset
   initial begin
      logic [15:0] v;
      logic a;
      do_reset;
      foreach (rows[i]) begin
         if (rows[i].src == 2'h1) begin
            wr(rows[i].ptr, rows[i].din);
         end else if (rows[i].src != 2'h0) begin
            pulse(rows[i].src, rows[i].ch, rows[i].din);
         end
         rd(rows[i].ptr, v);
         chk("register", v, rows[i].exp);
      end
      pulse(2'h0, 2'h1, 16'h1238);
      fl(3'b101);
      pulse(2'h0, 2'h1, 16'h1237);
      fl(3'b001);
      pulse(2'h2, 2'h1, 16'h8000);
      fl(3'b000);
      pulse(2'h0, 2'h1, 16'h8000);
      fl(3'b000);
      pulse(2'h2, 2'h1, 16'h0000);
      fl(3'b001);
      pulse(2'h0, 2'h1, 16'h7FF8);
      fl(3'b101);
      @(posedge clk_sys);
      conv_shunt_valid <= 1'b1;
      conv_shunt_chan <= 2'h2;
      conv_shunt_data <= 16'h0008;
      @(posedge clk_sys);
      conv_shunt_chan <= 2'h1;
      conv_shunt_data <= 16'h1230;
      @(posedge clk_sys);
      conv_shunt_valid <= 1'b0;
      #1;
      fl(3'b011);
      pulse(2'h0, 2'h2, 16'h8000);
      pulse(2'h0, 2'h3, 16'h7FF8);
      fl(3'b001);
      wr(8'h07, 16'hFFF0);
      pulse(2'h0, 2'h1, 16'hFFF8);
      fl(3'b101);
      // Burst write: the second word lands on the same pointer
      host_u.start;
      host_u.wb({`SBR_DEV_ADDR, 1'b0}, a);
      host_u.wb(8'h09, a);
      host_u.wb(8'h11, a);
      host_u.wb(8'h11, a);
      host_u.wb(8'h22, a);
      host_u.wb(8'h2F, a);
      host_u.stop;
      rd(8'h09, v);
      chk("burst write", v, 16'h2228);
      host_u.start;
      host_u.wb({`SBR_DEV_ADDR ^ 7'h01, 1'b0}, a);
      host_u.stop;
      chk("foreign address ack", {15'h0000, a}, 16'h0000);
      do_reset;
      fl(3'b000);
      rd(8'h07, v);
      chk("limit after reset", v, 16'h7FF8);
      rd(8'h05, v);
      chk("result after reset", v, 16'h0000);
      test_done;
   end
endmodule // sbr_top_tb
bind sbr_top sbr_chk chk_u (.clk_sys, .reset_n, .scl_in, .sda_in, .sda_out, .sda_oe,
   .conv_shunt_valid, .conv_shunt_chan, .conv_shunt_data, .avg_shunt_valid,
   .avg_shunt_chan, .avg_shunt_data, .bus_valid, .bus_chan, .bus_data,
   .chan1_fast_flag, .chan2_fast_flag, .chan1_slow_flag);
`default_nettype wire
